// File: leaky_bucket_map.svh
`ifndef LEAKY_BUCKET_MAP_SVH
`define LEAKY_BUCKET_MAP_SVH
// Register indices; byte address is four times the index
`define LB_IDX_S1_RAISE 7'h54
`define LB_IDX_S1_CLEAR 7'h55
`define LB_IDX_S1_SIZE  7'h56
`define LB_IDX_S1_RATE  7'h57
`define LB_IDX_S2_RAISE 7'h58
`define LB_IDX_S2_CLEAR 7'h59
`define LB_IDX_S2_SIZE  7'h5a
`define LB_IDX_S2_RATE  7'h5b
`define LB_IDX_SET_SEL  7'h70
`define LB_IDX_ALARM    7'h71
`define LB_IDX_ACC_BASE 7'h72
// Reset values
`define LB_RST_RAISE    8'h06
`define LB_RST_CLEAR    8'h04
`define LB_RST_SIZE     8'h08
`define LB_RST_RATE     2'h1
`define LB_RST_SEL      4'h0
// Field positions
`define LB_RATE_MSB     1
`define LB_RATE_LSB     0
// Evaluation cycle timing
`define LB_EVAL_MS      128
`define LB_CLK_KHZ      40000
`define LB_EVAL_CYCLES  (`LB_EVAL_MS * `LB_CLK_KHZ)
`define LB_NUM_IN       4
// Bus answers
`define LB_RESP_OKAY    2'b00
`define LB_RESP_SLVERR  2'b10
`endif

// File: lb_pkg.sv
package lb_pkg;
  typedef logic [7:0] level_t;
  typedef enum logic [2:0] {
    RID_NONE, RID_RAISE, RID_CLEAR, RID_SIZE, RID_RATE, RID_SEL, RID_ALARM, RID_ACC
  } reg_id_t;
  typedef struct packed {
    reg_id_t    id;
    logic [1:0] num;
  } reg_dec_t;
  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_t;
endpackage : lb_pkg

// File: bucket_if.sv
`timescale 1ns/1ps
interface bucket_if;
  import lb_pkg::*;
  logic       tick;
  logic       fault;
  level_t     raise;
  level_t     clear;
  level_t     size;
  logic [1:0] rate;
  level_t     acc;
  logic       alarm;
  modport ctrl   (output tick, fault, raise, clear, size, rate, input acc, alarm);
  modport bucket (input tick, fault, raise, clear, size, rate, output acc, alarm);
endinterface : bucket_if

// File: leaky_bucket_channel.sv
`timescale 1ns/1ps
module leaky_bucket_channel (
  input  wire logic i_clk,  // System clock
  input  wire logic i_rst,  // Synchronous reset, active high
  bucket_if.bucket  bus     // Config in, accumulator and alarm out
);
  import lb_pkg::*;

  logic       seen_reg;
  logic [2:0] leak_cnt_reg;
  level_t     acc_reg;
  logic       alarm_reg;
  logic       fault_now;

  function automatic logic [2:0] leak_limit(input logic [1:0] rate);
    leak_limit = 3'((4'h1 << rate) - 4'h1);
  endfunction : leak_limit

  // Fault in the tick cycle still counts for the closing cycle
  assign fault_now = seen_reg | bus.fault;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      seen_reg <= 1'b0;
    end else if (bus.tick) begin
      seen_reg <= 1'b0;
    end else if (bus.fault) begin
      seen_reg <= 1'b1; // RL1
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_reg      <= 8'h00; // RL9
      leak_cnt_reg <= 3'h0;
    end else if (bus.tick) begin
      if (fault_now) begin
        leak_cnt_reg <= 3'h0;
        if (acc_reg < bus.size) begin
          acc_reg <= acc_reg + 8'h01; // RL2 RL7
        end
      end else if (leak_cnt_reg >= leak_limit(bus.rate)) begin
        leak_cnt_reg <= 3'h0;
        if (acc_reg != 8'h00) begin
          acc_reg <= acc_reg - 8'h01; // RL3 RL4
        end
      end else begin
        leak_cnt_reg <= leak_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alarm_reg <= 1'b0; // RL9
    end else if (alarm_reg && acc_reg <= bus.clear) begin
      alarm_reg <= 1'b0; // RL6
    end else if (!alarm_reg && acc_reg >= bus.raise) begin
      alarm_reg <= 1'b1; // RL5
    end
  end

  assign bus.acc   = acc_reg;
  assign bus.alarm = alarm_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence faulty_tick; bus.tick && fault_now; endsequence
  sequence clean_tick; bus.tick && !fault_now; endsequence

  seen_latch_a: assert property (bus.fault && !bus.tick |=> seen_reg) // RL1
    else $error("Fault not latched");
  acc_step_a: assert property (faulty_tick ##0 acc_reg < bus.size
    |=> acc_reg == $past(acc_reg) + 8'h01) // RL2
    else $error("Accumulator did not add one");
  acc_sat_a: assert property (faulty_tick ##0 acc_reg >= bus.size
    |=> acc_reg == $past(acc_reg)) // RL7
    else $error("Accumulator passed saturation");
  acc_floor_a: assert property (clean_tick ##0 acc_reg == 8'h00 |=> acc_reg == 8'h00) // RL3
    else $error("Accumulator went below zero");
  leak_rate_a: assert property (clean_tick ##0 acc_reg != 8'h00
    ##0 leak_cnt_reg == leak_limit(bus.rate)
    |=> acc_reg == $past(acc_reg) - 8'h01) // RL4
    else $error("Leak step missing");
  alarm_raise_a: assert property (!alarm_reg && acc_reg >= bus.raise |=> alarm_reg) // RL5
    else $error("Alarm not raised");
  alarm_hold_a: assert property (alarm_reg && acc_reg > bus.clear |=> alarm_reg) // RL9
    else $error("Alarm dropped above clear level");
  alarm_clear_a: assert property (alarm_reg && acc_reg <= bus.clear |=> !alarm_reg) // RL6
    else $error("Alarm not cleared");
  reset_zero_a: assert property (disable iff (1'b0)
    i_rst |=> acc_reg == 8'h00 && !alarm_reg) // RL9
    else $error("Reset state wrong");
endmodule : leaky_bucket_channel

// File: leaky_bucket_activity_monitor.sv
// What this block does
// RL1 - Each input is judged over back-to-back 128 ms cycles, noting any fault in the cycle.
// RL2 - Each faulty cycle adds exactly one to that input's accumulator, up to saturation.
// RL3 - Each leak period of fault-free cycles subtracts one, never below zero.
// RL4 - Leak code 00/01/10/11 gives one decrement per 128/256/512/1024 ms.
// RL5 - Reaching the raise level asserts the input's inactivity alarm.
// RL6 - Falling to the clear level with the alarm set deasserts it.
// RL7 - The accumulator holds at the saturation size and never passes it.
// RL8 - Sets 1 and 2 are independent; an input uses only its assigned set.
// RL9 - Reset zeroes accumulators and alarms; alarm holds between levels.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "leaky_bucket_map.svh"
module leaky_bucket_activity_monitor #(
  parameter int unsigned P_EVAL_CYCLES = `LB_EVAL_CYCLES  // Clocks per evaluation cycle
) (
  input  wire logic        I_CLK,      // 40 MHz system clock
  input  wire logic        I_SYS_RST,  // Synchronous reset, active high
  input  wire logic [11:0] I_AWADDR,   // Write address
  input  wire logic        I_AWVALID,  // Write address valid
  output logic             O_AWREADY,  // Write address ready
  input  wire logic [31:0] I_WDATA,    // Write data
  input  wire logic [3:0]  I_WSTRB,    // Write byte strobes
  input  wire logic        I_WVALID,   // Write data valid
  output logic             O_WREADY,   // Write data ready
  output logic [1:0]       O_BRESP,    // Write response
  output logic             O_BVALID,   // Write response valid
  input  wire logic        I_BREADY,   // Write response ready
  input  wire logic [11:0] I_ARADDR,   // Read address
  input  wire logic        I_ARVALID,  // Read address valid
  output logic             O_ARREADY,  // Read address ready
  output logic [31:0]      O_RDATA,    // Read data
  output logic [1:0]       O_RRESP,    // Read response
  output logic             O_RVALID,   // Read data valid
  input  wire logic        I_RREADY,   // Read data ready
  input  wire logic [3:0]  I_FAULT,    // Per-input fail or erratic level
  output logic [3:0]       O_ALARM     // Per-input inactivity alarm
);
  import lb_pkg::*;

  localparam int NI = `LB_NUM_IN;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by both bus paths

  function automatic reg_dec_t decode(input logic [11:0] a);
    reg_dec_t   d;
    logic [6:0] i;
    d.id  = RID_NONE;
    d.num = 2'd0;
    i     = a[8:2];
    if (a[11:9] == 3'b000) begin
      case (i)
        `LB_IDX_S1_RAISE: d.id = RID_RAISE;
        `LB_IDX_S1_CLEAR: d.id = RID_CLEAR;
        `LB_IDX_S1_SIZE:  d.id = RID_SIZE;
        `LB_IDX_S1_RATE:  d.id = RID_RATE;
        `LB_IDX_S2_RAISE: begin
          d.id  = RID_RAISE;
          d.num = 2'd1;
        end
        `LB_IDX_S2_CLEAR: begin
          d.id  = RID_CLEAR;
          d.num = 2'd1;
        end
        `LB_IDX_S2_SIZE: begin
          d.id  = RID_SIZE;
          d.num = 2'd1;
        end
        `LB_IDX_S2_RATE: begin
          d.id  = RID_RATE;
          d.num = 2'd1;
        end
        `LB_IDX_SET_SEL:  d.id = RID_SEL;
        `LB_IDX_ALARM:    d.id = RID_ALARM;
        default: begin
          if (i >= `LB_IDX_ACC_BASE && i < `LB_IDX_ACC_BASE + 7'(NI)) begin
            d.id  = RID_ACC;
            d.num = 2'(i - `LB_IDX_ACC_BASE);
          end
        end
      endcase
    end
    return d;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////////
  // Evaluation timebase

  logic [22:0] tick_cnt_reg;
  logic        tick_reg;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      tick_cnt_reg <= 23'h0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 23'(P_EVAL_CYCLES - 1)) begin
      tick_cnt_reg <= 23'h0;
      tick_reg     <= 1'b1; // RL1
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 23'h1;
      tick_reg     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel

  wr_state_t   wr_state_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0]  wr_strb_reg;
  logic        wr_fire;
  reg_dec_t    wr_dec;

  assign wr_fire = (wr_state_reg == WR_IDLE) && aw_held_reg && w_held_reg;
  assign wr_dec  = decode(wr_addr_reg);

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      wr_state_reg <= WR_IDLE;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awready_reg  <= 1'b1;
      wready_reg   <= 1'b1;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= `LB_RESP_OKAY;
      wr_addr_reg  <= 12'h000;
      wr_data_reg  <= 32'h0000_0000;
      wr_strb_reg  <= 4'h0;
    end else begin
      case (wr_state_reg)
        WR_IDLE: begin
          if (I_AWVALID && awready_reg) begin
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
            wr_addr_reg <= I_AWADDR;
          end
          if (I_WVALID && wready_reg) begin
            w_held_reg  <= 1'b1;
            wready_reg  <= 1'b0;
            wr_data_reg <= I_WDATA;
            wr_strb_reg <= I_WSTRB;
          end
          if (wr_fire) begin
            wr_state_reg <= WR_RESP;
            bvalid_reg   <= 1'b1;
            bresp_reg    <= (wr_dec.id == RID_NONE) ? `LB_RESP_SLVERR : `LB_RESP_OKAY;
          end
        end
        WR_RESP: begin
          if (I_BREADY) begin
            wr_state_reg <= WR_IDLE;
            bvalid_reg   <= 1'b0;
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awready_reg  <= 1'b1;
            wready_reg   <= 1'b1;
          end
        end
        default: wr_state_reg <= WR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration sets and input assignment

  level_t     raise_reg [2];
  level_t     clear_reg [2];
  level_t     size_reg  [2];
  logic [1:0] rate_reg  [2];
  logic [3:0] sel_reg;
  logic       wr_low;

  // Registers hold at most eight bits, so only lane 0 matters
  assign wr_low = wr_fire && wr_strb_reg[0];

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      for (int s = 0; s < 2; s++) begin
        raise_reg[s] <= `LB_RST_RAISE;
        clear_reg[s] <= `LB_RST_CLEAR;
        size_reg[s]  <= `LB_RST_SIZE;
        rate_reg[s]  <= `LB_RST_RATE;
      end
    end else if (wr_low) begin
      for (int s = 0; s < 2; s++) begin
        if (wr_dec.num == 2'(s)) begin
          case (wr_dec.id)
            RID_RAISE: raise_reg[s] <= wr_data_reg[7:0]; // RL8
            RID_CLEAR: clear_reg[s] <= wr_data_reg[7:0]; // RL8
            RID_SIZE:  size_reg[s]  <= wr_data_reg[7:0]; // RL8
            RID_RATE:  rate_reg[s]  <= wr_data_reg[`LB_RATE_MSB:`LB_RATE_LSB]; // RL4
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      sel_reg <= `LB_RST_SEL;
    end else if (wr_low && wr_dec.id == RID_SEL) begin
      sel_reg <= wr_data_reg[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-input accumulators

  bucket_if bif [NI] ();
  level_t     acc_vec [NI];
  logic [3:0] alarm_vec;

  for (genvar g = 0; g < NI; g++) begin : g_ch
    assign bif[g].tick  = tick_reg;
    assign bif[g].fault = I_FAULT[g];
    assign bif[g].raise = raise_reg[sel_reg[g]]; // RL8
    assign bif[g].clear = clear_reg[sel_reg[g]]; // RL8
    assign bif[g].size  = size_reg[sel_reg[g]]; // RL8
    assign bif[g].rate  = rate_reg[sel_reg[g]]; // RL8
    assign acc_vec[g]   = bif[g].acc;
    assign alarm_vec[g] = bif[g].alarm;

    leaky_bucket_channel u_ch (
      .i_clk (I_CLK),
      .i_rst (I_SYS_RST),
      .bus   (bif[g])
    );
  end

  logic [3:0] alarm_out_reg;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      alarm_out_reg <= 4'h0;
    end else begin
      alarm_out_reg <= alarm_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel

  rd_state_t   rd_state_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_word;
  reg_dec_t    rd_dec;

  assign rd_dec = decode(I_ARADDR);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_dec.id)
      RID_RAISE: rd_word = {24'h0, raise_reg[rd_dec.num[0]]};
      RID_CLEAR: rd_word = {24'h0, clear_reg[rd_dec.num[0]]};
      RID_SIZE:  rd_word = {24'h0, size_reg[rd_dec.num[0]]};
      RID_RATE:  rd_word = {30'h0, rate_reg[rd_dec.num[0]]};
      RID_SEL:   rd_word = {28'h0, sel_reg};
      RID_ALARM: rd_word = {28'h0, alarm_vec};
      RID_ACC:   rd_word = {24'h0, acc_vec[rd_dec.num]};
      default:   rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rd_state_reg <= RD_IDLE;
      arready_reg  <= 1'b1;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= `LB_RESP_OKAY;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          if (I_ARVALID) begin
            rd_state_reg <= RD_DATA;
            arready_reg  <= 1'b0;
            rvalid_reg   <= 1'b1;
            rdata_reg    <= rd_word;
            rresp_reg    <= (rd_dec.id == RID_NONE) ? `LB_RESP_SLVERR : `LB_RESP_OKAY;
          end
        end
        RD_DATA: begin
          if (I_RREADY) begin
            rd_state_reg <= RD_IDLE;
            arready_reg  <= 1'b1;
            rvalid_reg   <= 1'b0;
          end
        end
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign O_AWREADY = awready_reg;
  assign O_WREADY  = wready_reg;
  assign O_BVALID  = bvalid_reg;
  assign O_BRESP   = bresp_reg;
  assign O_ARREADY = arready_reg;
  assign O_RVALID  = rvalid_reg;
  assign O_RRESP   = rresp_reg;
  assign O_RDATA   = rdata_reg;
  assign O_ALARM   = alarm_out_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence set2_raise_write;
    wr_low && wr_dec.id == RID_RAISE && wr_dec.num == 2'd1;
  endsequence

  sequence set2_size_write;
    wr_low && wr_dec.id == RID_SIZE && wr_dec.num == 2'd1;
  endsequence

  tick_period_a: assert property (tick_reg |-> $past(tick_cnt_reg) == 23'(P_EVAL_CYCLES - 1)) // RL1
    else $error("Tick off period");
  tick_gap_a: assert property (tick_reg |=> !tick_reg [*8]) // RL1
    else $error("Ticks too close");
  set_isolate_a: assert property (set2_raise_write ##0 !sel_reg[0]
    |=> $stable(bif[0].raise)) // RL8
    else $error("Set 2 write leaked into set 1 input");
  set_size_a: assert property (set2_size_write ##0 sel_reg[1]
    |=> bif[1].size == $past(wr_data_reg[7:0])) // RL8
    else $error("Set 2 size not routed");
  alarm_out_a: assert property (1'b1 |=> O_ALARM == $past(alarm_vec)) // RL5
    else $error("Alarm output lags wrong");
  bad_write_a: assert property (wr_fire && wr_dec.id == RID_NONE
    |=> O_BVALID && O_BRESP == `LB_RESP_SLVERR)
    else $error("Unmapped write not refused");
  bresp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("Write response dropped");
  rd_answer_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
    else $error("Read not answered");
endmodule : leaky_bucket_activity_monitor

// File: lb_fault_src.sv
`timescale 1ns/1ps
module lb_fault_src (
  input  wire logic       i_clk,   // System clock
  input  wire logic       i_rst,   // Synchronous reset, active high
  input  wire logic       i_arm,   // Start one faulty evaluation cycle
  input  wire logic [3:0] i_mask,  // Inputs that misbehave this cycle
  input  wire logic [3:0] i_dly,   // Clocks from arm to the glitch
  output logic      [3:0] o_fault  // Fail or erratic indication per input
);
  logic [3:0] mask_reg;
  logic [3:0] cnt_reg;

  // Short glitch well inside the evaluation cycle, quiet otherwise
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mask_reg <= 4'h0;
      cnt_reg  <= 4'h0;
      o_fault  <= 4'h0;
    end else begin
      o_fault <= (cnt_reg == 4'h1) ? mask_reg : 4'h0;
      if (i_arm) begin
        mask_reg <= i_mask;
        cnt_reg  <= i_dly;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule : lb_fault_src

// File: leaky_bucket_activity_monitor_test.sv
`timescale 1ns/1ps
`include "leaky_bucket_map.svh"
module leaky_bucket_activity_monitor_test;
  import lb_pkg::*;
  localparam int P = 32;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0]  wstrb = 0, fault, alarm, f_mask = 0, f_dly = 0, next_mask = 0, next_dly = 1;
  logic [3:0]  armed_mask = 0;
  logic        arm = 0;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid;
  int          n_mismatch = 0, checks = 0, ecnt = 0, tick_cnt = 0;
  level_t      raise_s [2] = '{8'h06, 8'h06};
  level_t      clear_s [2] = '{8'h04, 8'h04};
  level_t      size_s  [2] = '{8'h08, 8'h08};
  logic [1:0]  rate_s  [2] = '{2'h1, 2'h1};
  logic [3:0]  sel_s = 4'h0;
  level_t      acc_m [4];
  logic [3:0]  cnt_m [4];
  logic [3:0]  al_m;
  logic [11:0] st;
  logic [6:0]  rst_idx [10] = '{`LB_IDX_S1_RAISE, `LB_IDX_S1_CLEAR, `LB_IDX_S1_SIZE,
    `LB_IDX_S1_RATE, `LB_IDX_S2_RAISE, `LB_IDX_S2_CLEAR, `LB_IDX_S2_SIZE, `LB_IDX_S2_RATE,
    `LB_IDX_SET_SEL, `LB_IDX_ALARM};
  logic [7:0]  rst_exp [10] = '{8'h06, 8'h04, 8'h08, 8'h01, 8'h06, 8'h04, 8'h08, 8'h01,
    8'h00, 8'h00};

  always #12.5 clk = ~clk;

  leaky_bucket_activity_monitor #(.P_EVAL_CYCLES(P)) u_leaky_bucket_activity_monitor (
    .I_CLK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_FAULT(fault), .O_ALARM(alarm));

  lb_fault_src u_lb_fault_src (
    .i_clk(clk), .i_rst(rst), .i_arm(arm), .i_mask(f_mask), .i_dly(f_dly), .o_fault(fault));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] leak_step(level_t a, logic [3:0] c, logic f, level_t sz,
                                            logic [1:0] rt);
    if (f) return {4'h0, (a < sz) ? a + 8'h01 : a};
    if (c >= (4'h1 << rt) - 4'h1) return {4'h0, (a != 8'h00) ? a - 8'h01 : a};
    return {c + 4'h1, a};
  endfunction : leak_step

  function automatic logic alarm_step(logic al, level_t a, level_t rsl, level_t cl);
    if (a <= cl) return 1'b0;
    if (a >= rsl) return 1'b1;
    return al;
  endfunction : alarm_step

  function automatic logic [11:0] ba(logic [6:0] i);
    return {3'h0, i, 2'h0};
  endfunction : ba

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s resp %b exp %b", $time, what, got, exp);
    end
  endtask : cmp_resp

  task automatic cmp_alarm(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t alarm %b exp %b", $time, got, exp);
    end
  endtask : cmp_alarm

  ////////////////////////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    bit got;
    got = 0;
    r = 2'bxx;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // No cycle limit here; the watchdog ends a hung transfer
    while (!got) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        got = 1;
        bready <= 1'b0;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    r = 2'bxx;
    d = 'x;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        got = 1;
        rready <= 1'b0;
      end
    end
  endtask : axi_read

  task automatic wait_tick();
    int t0;
    t0 = tick_cnt;
    while (tick_cnt == t0) @(posedge clk);
  endtask : wait_tick

  // One set's four registers, shadow follows each accepted write
  task automatic set_cfg(input int s, input level_t rsl, cl, sz, input logic [1:0] rt);
    logic [6:0] b;
    b = `LB_IDX_S1_RAISE + 7'(4 * s);
    axi_write(ba(b), {24'h0, rsl}, 4'h1, rs);
    raise_s[s] = rsl;
    axi_write(ba(b + 7'h1), {24'h0, cl}, 4'h1, rs);
    clear_s[s] = cl;
    axi_write(ba(b + 7'h2), {24'h0, sz}, 4'h1, rs);
    size_s[s] = sz;
    axi_write(ba(b + 7'h3), {30'h0, rt}, 4'h1, rs);
    rate_s[s] = rt;
  endtask : set_cfg

  task automatic run(input int n, input int mode);
    for (int i = 0; i < n; i++) begin
      next_mask = (mode == 0) ? 4'h0 : (mode == 1) ? 4'hf : 4'($urandom);
      next_dly  = 4'($urandom_range(8, 1));
      wait_tick();
    end
  endtask : run

  task tally_and_finish;
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  // Evaluation timeline, fault arming and reference bucket
  always @(posedge clk) begin
    if (rst) begin
      ecnt <= 0;
      arm  <= 1'b0;
      al_m = 4'h0;
      for (int k = 0; k < 4; k++) begin
        acc_m[k] = 8'h00;
        cnt_m[k] = 4'h0;
      end
    end else begin
      ecnt <= ecnt + 1;
      arm  <= (ecnt % P == 12);
      if (ecnt % P == 12) begin
        armed_mask = next_mask;
        f_mask <= next_mask;
        f_dly  <= next_dly;
      end
      if (ecnt % P == P - 1) begin
        for (int k = 0; k < 4; k++) begin
          st = leak_step(acc_m[k], cnt_m[k], armed_mask[k], size_s[sel_s[k]], rate_s[sel_s[k]]);
          acc_m[k] = st[7:0];
          cnt_m[k] = st[11:8];
          al_m[k] = alarm_step(al_m[k], acc_m[k], raise_s[sel_s[k]], clear_s[sel_s[k]]);
        end
        armed_mask = 4'h0;
        tick_cnt++;
      end
      if (ecnt % P == 6 && ecnt > P) cmp_alarm(alarm, al_m);
    end
  end

  initial begin
    #(20000 * 25);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h19a02f35));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      axi_read(ba(rst_idx[i]), rd, rs);
      cmp_word(rd, {24'h0, rst_exp[i]}, "reset value");
    end
    for (int k = 0; k < 4; k++) begin
      axi_read(ba(`LB_IDX_ACC_BASE + 7'(k)), rd, rs);
      cmp_word(rd, 32'h0, "reset accumulator");
    end
    axi_write(ba(`LB_IDX_S1_RAISE), 32'hff, 4'h0, rs);
    axi_read(ba(`LB_IDX_S1_RAISE), rd, rs);
    cmp_word(rd, 32'h06, "strobe off write");
    axi_write(ba(`LB_IDX_ACC_BASE), 32'h33, 4'hf, rs);
    cmp_resp(rs, `LB_RESP_OKAY, "read-only write");
    axi_read(ba(`LB_IDX_ACC_BASE), rd, rs);
    cmp_word(rd, 32'h0, "read-only kept");
    axi_write(12'h800, 32'h1, 4'hf, rs);
    cmp_resp(rs, `LB_RESP_SLVERR, "unmapped write");
    axi_read(12'h800, rd, rs);
    cmp_resp(rs, `LB_RESP_SLVERR, "unmapped read");
    cmp_word(rd, 32'h0, "unmapped data");
    axi_write(ba(`LB_IDX_S2_RAISE), 32'hffffff03, 4'hf, rs);
    axi_read(ba(`LB_IDX_S2_RAISE), rd, rs);
    cmp_word(rd, 32'h03, "upper bits");
    raise_s[1] = 8'h03;
    axi_write(ba(`LB_IDX_SET_SEL), 32'ha, 4'h1, rs);
    sel_s = 4'ha;
    for (int r = 0; r < 4; r++) begin
      next_mask = 4'h0;
      wait_tick();
      set_cfg(0, 8'h06, 8'h04, 8'h08, 2'(r));
      wait_tick();
      set_cfg(1, 8'h03, 8'h01, 8'h05, 2'(3 - r));
      run(10, 1);
      run(12, 2);
      run(18, 0);
      wait_tick();
      repeat (4) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        axi_read(ba(`LB_IDX_ACC_BASE + 7'(k)), rd, rs);
        cmp_word(rd, {24'h0, acc_m[k]}, "accumulator");
        cmp_resp(rs, `LB_RESP_OKAY, "accumulator read");
      end
      axi_read(ba(`LB_IDX_ALARM), rd, rs);
      cmp_word(rd, {28'h0, al_m}, "alarm status");
    end
    tally_and_finish();
  end
endmodule : leaky_bucket_activity_monitor_test
